// ==== src/qmc_mixer_pkg.sv ====
// Constants, register map and carrier types for the correction and mixer register slice.
package qmc_mixer_pkg;

    // ------------------------------------------------------------------
    // Bus and register map (word index; byte address is four times it)
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam logic [5:0]  IDX_I_GAIN      = 6'h0C;
    localparam logic [5:0]  IDX_COARSE      = 6'h0D;
    localparam logic [5:0]  IDX_RSVD_A      = 6'h0E;
    localparam logic [5:0]  IDX_DELAY       = 6'h0F;
    localparam logic [5:0]  IDX_PHASE       = 6'h10;
    localparam logic [5:0]  IDX_RSVD_B      = 6'h11;
    localparam logic [5:0]  IDX_OSC_OFS     = 6'h12;
    localparam logic [5:0]  IDX_STEP_LO     = 6'h14;
    localparam logic [5:0]  IDX_STEP_HI     = 6'h15;
    localparam logic [5:0]  IDX_ACTIVE_STAT = 6'h1C;
    localparam logic [5:0]  IDX_GROUP_LOAD  = 6'h1D;
    localparam logic [5:0]  IDX_CORR_EN     = 6'h1E;
    localparam logic [5:0]  IDX_MIX_EN      = 6'h1F;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [10:0] RST_GAIN        = 11'h400;
    localparam logic [15:0] RST_RSVD_A      = 16'h0400;
    localparam logic [15:0] RST_RSVD_B      = 16'h0000;
    localparam logic [10:0] RST_DELAY_LOW   = 11'h400;
    localparam int          CMIX_FS8_BIT    = 15;
    localparam int          CMIX_FS4_BIT    = 14;
    localparam int          CMIX_FS2_BIT    = 13;
    localparam int          CMIX_NFS4_BIT   = 12;
    localparam int          DELAY_LSB       = 14;
    localparam int          PHASE_KEEP_MSB  = 13;
    localparam int          CORR_LOAD_BIT   = 0;
    localparam int          MIX_LOAD_BIT    = 1;

    // ------------------------------------------------------------------
    // Arithmetic constants
    // ------------------------------------------------------------------
    localparam logic [2:0]  ROT_FS8         = 3'h1;
    localparam logic [2:0]  ROT_FS4         = 3'h2;
    localparam logic [2:0]  ROT_FS2         = 3'h4;
    localparam logic [2:0]  ROT_NFS4        = 3'h6;
    localparam logic [2:0]  ROT_QUARTER     = 3'h2;
    localparam int          GAIN_FRAC       = 10;
    localparam int          PHASE_FRAC      = 12;
    localparam int          TRIG_FRAC       = 14;
    localparam logic signed [17:0] TRIG_ONE  = 18'sh04000;
    localparam logic signed [17:0] TRIG_ROOT = 18'sh02D41;
    localparam logic signed [35:0] SAT_MAX   = 36'sh000007FFF;
    localparam logic signed [35:0] SAT_MIN   = -36'sh000008000;

    typedef struct packed {
        logic signed [15:0] a;
        logic signed [15:0] b;
    } sample_pair_type;

    typedef struct packed {
        logic [10:0] i_gain;
        logic [10:0] q_gain;
        logic [11:0] phase;
    } correction_set_type;

    typedef struct packed {
        logic [31:0] step;
        logic [15:0] offset;
    } mixer_set_type;

endpackage

// ==== src/qmc_mixer_shadow_regs.sv ====
// APB register slice with shadow group loads feeding the correction and mixer datapath.
`timescale 1ns/1ps
module qmc_mixer_shadow_regs (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [7:0]                     paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire qmc_mixer_pkg::sample_pair_type sample_in,
    output qmc_mixer_pkg::sample_pair_type      sample_out,
    output logic      [15:0]                    osc_table_addr
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic signed [15:0] sat16(input logic signed [35:0] v);
        if (v > qmc_mixer_pkg::SAT_MAX) begin
            sat16 = 16'sh7FFF;
        end else if (v < qmc_mixer_pkg::SAT_MIN) begin
            sat16 = -16'sh8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction

    function automatic logic signed [17:0] cos_q14(input logic [2:0] idx);
        case (idx)
            3'h0:    cos_q14 = qmc_mixer_pkg::TRIG_ONE;
            3'h1:    cos_q14 = qmc_mixer_pkg::TRIG_ROOT;
            3'h2:    cos_q14 = 18'sh00000;
            3'h3:    cos_q14 = -qmc_mixer_pkg::TRIG_ROOT;
            3'h4:    cos_q14 = -qmc_mixer_pkg::TRIG_ONE;
            3'h5:    cos_q14 = -qmc_mixer_pkg::TRIG_ROOT;
            3'h6:    cos_q14 = 18'sh00000;
            default: cos_q14 = qmc_mixer_pkg::TRIG_ROOT;
        endcase
    endfunction

    function automatic logic reg_known(input logic [5:0] idx);
        case (idx)
            qmc_mixer_pkg::IDX_I_GAIN, qmc_mixer_pkg::IDX_COARSE,
            qmc_mixer_pkg::IDX_RSVD_A, qmc_mixer_pkg::IDX_DELAY,
            qmc_mixer_pkg::IDX_PHASE, qmc_mixer_pkg::IDX_RSVD_B,
            qmc_mixer_pkg::IDX_OSC_OFS, qmc_mixer_pkg::IDX_STEP_LO,
            qmc_mixer_pkg::IDX_STEP_HI, qmc_mixer_pkg::IDX_ACTIVE_STAT,
            qmc_mixer_pkg::IDX_GROUP_LOAD, qmc_mixer_pkg::IDX_CORR_EN,
            qmc_mixer_pkg::IDX_MIX_EN: reg_known = 1'b1;
            default:                   reg_known = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [10:0]                        i_gain_hold_reg;
    logic [10:0]                        q_gain_hold_reg;
    logic [3:0]                         cmix_mode_reg;
    logic [1:0]                         delay_reg;
    logic [13:0]                        phase_hold_reg;
    logic [15:0]                        offset_hold_reg;
    logic [15:0]                        step_lo_hold_reg;
    logic [15:0]                        step_hi_hold_reg;
    logic                               corr_sync_en_reg;
    logic                               mix_sync_en_reg;
    qmc_mixer_pkg::correction_set_type  corr_active_reg;
    qmc_mixer_pkg::mixer_set_type       mix_active_reg;
    logic [2:0]                         rot_step;
    logic [2:0]                         rot_phase_reg;
    qmc_mixer_pkg::sample_pair_type     mix_reg;
    qmc_mixer_pkg::sample_pair_type     mix_next;
    qmc_mixer_pkg::sample_pair_type     gain_reg;
    qmc_mixer_pkg::sample_pair_type     gain_next;
    qmc_mixer_pkg::sample_pair_type     corr_reg;
    qmc_mixer_pkg::sample_pair_type     corr_next;
    qmc_mixer_pkg::sample_pair_type     dly_reg [3];
    logic [31:0]                        acc_reg;
    logic [5:0]                         idx;
    logic                               setup;
    logic                               wr_fire;
    logic                               corr_load;
    logic                               mix_load;
    logic [31:0]                        rdata_next;

    assign idx     = paddr[7:2];
    assign setup   = psel && !penable;
    // Writes take effect only at the access edge and only at a mapped aligned word.
    assign wr_fire = psel && penable && pready && pwrite && !pslverr;

    // ------------------------------------------------------------------
    // APB slave: one wait-free access phase, error on unmapped words
    // ------------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (idx)
            qmc_mixer_pkg::IDX_I_GAIN:      rdata_next[10:0] = i_gain_hold_reg;
            qmc_mixer_pkg::IDX_COARSE:      rdata_next[15:0] = {cmix_mode_reg, 1'b0,
                                                                q_gain_hold_reg};
            qmc_mixer_pkg::IDX_RSVD_A:      rdata_next[15:0] = qmc_mixer_pkg::RST_RSVD_A;
            qmc_mixer_pkg::IDX_DELAY:       rdata_next[15:0] = {delay_reg, 3'h0,
                                                                qmc_mixer_pkg::RST_DELAY_LOW};
            qmc_mixer_pkg::IDX_PHASE:       rdata_next[13:0] = phase_hold_reg;
            qmc_mixer_pkg::IDX_RSVD_B:      rdata_next[15:0] = qmc_mixer_pkg::RST_RSVD_B;
            qmc_mixer_pkg::IDX_OSC_OFS:     rdata_next[15:0] = offset_hold_reg;
            qmc_mixer_pkg::IDX_STEP_LO:     rdata_next[15:0] = step_lo_hold_reg;
            qmc_mixer_pkg::IDX_STEP_HI:     rdata_next[15:0] = step_hi_hold_reg;
            qmc_mixer_pkg::IDX_ACTIVE_STAT: rdata_next[11:0] = corr_active_reg.phase;
            qmc_mixer_pkg::IDX_CORR_EN:     rdata_next[0]    = corr_sync_en_reg;
            qmc_mixer_pkg::IDX_MIX_EN:      rdata_next[0]    = mix_sync_en_reg;
            default:                        rdata_next       = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !(reg_known(idx) && paddr[1:0] == 2'h0);
            prdata  <= (setup && !pwrite) ? rdata_next : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Holding registers written by software
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            i_gain_hold_reg  <= qmc_mixer_pkg::RST_GAIN;
            q_gain_hold_reg  <= qmc_mixer_pkg::RST_GAIN;
            cmix_mode_reg    <= 4'h0;
            delay_reg        <= 2'h0;
            phase_hold_reg   <= 14'h0000;
            offset_hold_reg  <= 16'h0000;
            step_lo_hold_reg <= 16'h0000;
            step_hi_hold_reg <= 16'h0000;
            corr_sync_en_reg <= 1'b0;
            mix_sync_en_reg  <= 1'b0;
        end else if (wr_fire) begin
            case (idx)
                qmc_mixer_pkg::IDX_I_GAIN:  i_gain_hold_reg  <= pwdata[10:0];
                qmc_mixer_pkg::IDX_COARSE: begin
                    cmix_mode_reg   <= pwdata[qmc_mixer_pkg::CMIX_FS8_BIT:
                                              qmc_mixer_pkg::CMIX_NFS4_BIT];
                    q_gain_hold_reg <= pwdata[10:0];
                end
                qmc_mixer_pkg::IDX_DELAY: delay_reg <= pwdata[qmc_mixer_pkg::DELAY_LSB +: 2];
                // Bits 13:12 are kept so software can set them as the part needs.
                qmc_mixer_pkg::IDX_PHASE:
                    phase_hold_reg <= pwdata[qmc_mixer_pkg::PHASE_KEEP_MSB:0];
                qmc_mixer_pkg::IDX_OSC_OFS: offset_hold_reg  <= pwdata[15:0];
                qmc_mixer_pkg::IDX_STEP_LO: step_lo_hold_reg <= pwdata[15:0];
                qmc_mixer_pkg::IDX_STEP_HI: step_hi_hold_reg <= pwdata[15:0];
                qmc_mixer_pkg::IDX_CORR_EN: corr_sync_en_reg <= pwdata[0];
                qmc_mixer_pkg::IDX_MIX_EN:  mix_sync_en_reg  <= pwdata[0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Group loads into the active settings
    // ------------------------------------------------------------------
    // The triggering word itself goes straight into the active set, so the
    // whole group changes on one edge and never shows a half-old value.
    assign corr_load = wr_fire && ((idx == qmc_mixer_pkg::IDX_PHASE && corr_sync_en_reg) ||
                       (idx == qmc_mixer_pkg::IDX_GROUP_LOAD &&
                        pwdata[qmc_mixer_pkg::CORR_LOAD_BIT]));
    assign mix_load  = wr_fire && ((idx == qmc_mixer_pkg::IDX_OSC_OFS && mix_sync_en_reg) ||
                       (idx == qmc_mixer_pkg::IDX_GROUP_LOAD &&
                        pwdata[qmc_mixer_pkg::MIX_LOAD_BIT]));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            corr_active_reg <= '{i_gain: qmc_mixer_pkg::RST_GAIN,
                                 q_gain: qmc_mixer_pkg::RST_GAIN, phase: 12'h000};
        end else if (corr_load) begin
            corr_active_reg.i_gain <= i_gain_hold_reg;
            corr_active_reg.q_gain <= q_gain_hold_reg;
            corr_active_reg.phase  <= (idx == qmc_mixer_pkg::IDX_PHASE) ? pwdata[11:0]
                                                                       : phase_hold_reg[11:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mix_active_reg <= '{step: 32'h0000_0000, offset: 16'h0000};
        end else if (mix_load) begin
            mix_active_reg.step   <= {step_hi_hold_reg, step_lo_hold_reg};
            mix_active_reg.offset <= (idx == qmc_mixer_pkg::IDX_OSC_OFS) ? pwdata[15:0]
                                                                        : offset_hold_reg;
        end
    end

    // ------------------------------------------------------------------
    // Coarse mixer: rotation by multiples of pi/4 per sample
    // ------------------------------------------------------------------
    always_comb begin
        rot_step = 3'h0;
        if (cmix_mode_reg[3]) rot_step = rot_step + qmc_mixer_pkg::ROT_FS8;
        if (cmix_mode_reg[2]) rot_step = rot_step + qmc_mixer_pkg::ROT_FS4;
        if (cmix_mode_reg[1]) rot_step = rot_step + qmc_mixer_pkg::ROT_FS2;
        if (cmix_mode_reg[0]) rot_step = rot_step + qmc_mixer_pkg::ROT_NFS4;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rot_phase_reg <= 3'h0;
        end else begin
            // A zero shift also rewinds the phase so no stale rotation is left.
            rot_phase_reg <= (rot_step == 3'h0) ? 3'h0 : rot_phase_reg + rot_step;
        end
    end

    always_comb begin
        logic signed [17:0] c;
        logic signed [17:0] s;
        logic signed [35:0] re;
        logic signed [35:0] im;
        c  = cos_q14(rot_phase_reg);
        s  = cos_q14(rot_phase_reg - qmc_mixer_pkg::ROT_QUARTER);
        re = 36'($signed(sample_in.a)) * 36'(c) - 36'($signed(sample_in.b)) * 36'(s);
        im = 36'($signed(sample_in.a)) * 36'(s) + 36'($signed(sample_in.b)) * 36'(c);
        mix_next.a = sat16(re >>> qmc_mixer_pkg::TRIG_FRAC);
        mix_next.b = sat16(im >>> qmc_mixer_pkg::TRIG_FRAC);
    end

    // ------------------------------------------------------------------
    // Gain and phase correction
    // ------------------------------------------------------------------
    always_comb begin
        logic signed [35:0] pa;
        logic signed [35:0] pb;
        pa = 36'($signed(mix_reg.a)) * 36'($signed({1'b0, corr_active_reg.i_gain}));
        pb = 36'($signed(mix_reg.b)) * 36'($signed({1'b0, corr_active_reg.q_gain}));
        gain_next.a = sat16(pa >>> qmc_mixer_pkg::GAIN_FRAC);
        gain_next.b = sat16(pb >>> qmc_mixer_pkg::GAIN_FRAC);
    end

    always_comb begin
        logic signed [35:0] prod;
        prod = 36'($signed(gain_reg.b)) * 36'($signed(corr_active_reg.phase));
        corr_next.a = sat16(36'(gain_reg.a) + (prod >>> qmc_mixer_pkg::PHASE_FRAC));
        corr_next.b = gain_reg.b;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mix_reg  <= '0;
            gain_reg <= '0;
            corr_reg <= '0;
        end else begin
            mix_reg  <= mix_next;
            gain_reg <= gain_next;
            corr_reg <= corr_next;
        end
    end

    // ------------------------------------------------------------------
    // Output delay line
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_reg[0] <= '0;
            dly_reg[1] <= '0;
            dly_reg[2] <= '0;
            sample_out <= '0;
        end else begin
            dly_reg[0] <= corr_reg;
            dly_reg[1] <= dly_reg[0];
            dly_reg[2] <= dly_reg[1];
            sample_out <= (delay_reg == 2'h0) ? corr_reg : dly_reg[delay_reg - 2'h1];
        end
    end

    // ------------------------------------------------------------------
    // Fine mixer phase accumulator and table address
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg        <= 32'h0000_0000;
            osc_table_addr <= 16'h0000;
        end else begin
            acc_reg        <= acc_reg + mix_active_reg.step;
            osc_table_addr <= acc_reg[31:16] + mix_active_reg.offset;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    coarse_bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) && $past(rot_phase_reg) == 3'h0 |-> mix_reg == $past(sample_in))
        else $error("Coarse mixer altered samples with no rotation.");

    rot_advance_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(cmix_mode_reg) == 4'h5
        |-> rot_phase_reg == 3'h0)
        else $error("Fs/4 with -Fs/4 must net to no shift.");

    q_gain_path_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> gain_reg.b == sat16(36'($signed($past(mix_reg.b))) *
                 $signed(36'($past(corr_active_reg.q_gain))) >>> qmc_mixer_pkg::GAIN_FRAC))
        else $error("Q gain product wrong.");

    delay_three_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(delay_reg) == 2'h3
        |-> sample_out == $past(corr_reg, 4))
        else $error("Output delay of three cycles not honoured.");

    phase_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> corr_reg.a == sat16(36'($past(gain_reg.a)) + (36'($signed($past(gain_reg.b))) *
                 36'($signed($past(corr_active_reg.phase))) >>> qmc_mixer_pkg::PHASE_FRAC)))
        else $error("Phase correction sum wrong.");

    corr_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_fire && idx == qmc_mixer_pkg::IDX_PHASE && corr_sync_en_reg
        |=> corr_active_reg == {$past(i_gain_hold_reg), $past(q_gain_hold_reg),
                                $past(pwdata[11:0])})
        else $error("Correction group did not load on phase write.");

    gain_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_fire && (idx == qmc_mixer_pkg::IDX_I_GAIN || idx == qmc_mixer_pkg::IDX_COARSE)
        |=> $stable(corr_active_reg))
        else $error("Gain write changed active correction.");

    table_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> osc_table_addr == 16'($past(acc_reg[31:16]) + $past(mix_active_reg.offset)))
        else $error("Table address is not accumulator plus offset.");

    mix_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_fire && idx == qmc_mixer_pkg::IDX_OSC_OFS && mix_sync_en_reg
        |=> mix_active_reg == {$past(step_hi_hold_reg), $past(step_lo_hold_reg),
                               $past(pwdata[15:0])})
        else $error("Mixer group did not load on offset write.");

    step_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_fire && (idx == qmc_mixer_pkg::IDX_STEP_LO || idx == qmc_mixer_pkg::IDX_STEP_HI)
        |=> $stable(mix_active_reg))
        else $error("Step word write changed active mixer.");

endmodule

// ==== testbench/test_qmc_mixer_shadow_regs.sv ====
// Self-checking testbench for the correction and mixer register slice.
`timescale 1ns/1ps
module test_qmc_mixer_shadow_regs;
    logic                           pclk = 1'b0;
    logic                           presetn = 1'b0;
    logic                           psel = 1'b0;
    logic                           penable = 1'b0;
    logic                           pwrite = 1'b0;
    logic [7:0]                     paddr = 8'h00;
    logic [31:0]                    pwdata = 32'h00000000;
    logic [31:0]                    prdata;
    logic                           pready;
    logic                           pslverr;
    qmc_mixer_pkg::sample_pair_type sample_in = 32'h10001000;
    qmc_mixer_pkg::sample_pair_type sample_out;
    logic [15:0]                    osc_table_addr;
    logic [31:0]                    rdata;
    logic                           rerr;
    logic [15:0]                    first;
    int                             errors = 0;
    int                             checks = 0;

    qmc_mixer_shadow_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_in(sample_in),
        .sample_out(sample_out), .osc_table_addr(osc_table_addr));

    always #2.5 pclk = ~pclk;

    // ------------------------------------------------------------------
    // Bus and checking tasks
    // ------------------------------------------------------------------
    // The request is held until pready is seen high at a rising edge.
    task automatic access(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) errors++;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
        access(1'b0, idx, 32'h00000000);
        check("register read", exp, rdata);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic complete_run;
        if (errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        cycles(8);
        presetn <= 1'b1;
        rd(qmc_mixer_pkg::IDX_COARSE, 32'h00000400);
        rd(qmc_mixer_pkg::IDX_RSVD_A, 32'h00000400);
        rd(qmc_mixer_pkg::IDX_PHASE, 32'h00000000);
        rd(qmc_mixer_pkg::IDX_RSVD_B, 32'h00000000);
        rd(qmc_mixer_pkg::IDX_OSC_OFS, 32'h00000000);
        access(1'b0, 6'h13, 32'h00000000);
        check("unmapped error", 32'h00000001, {31'h0, rerr});
        access(1'b1, qmc_mixer_pkg::IDX_RSVD_A, 32'h0000FFFF);
        rd(qmc_mixer_pkg::IDX_RSVD_A, 32'h00000400);
        access(1'b1, qmc_mixer_pkg::IDX_DELAY, 32'h0000C000);
        rd(qmc_mixer_pkg::IDX_DELAY, 32'h0000C400);
        cycles(10);
        check("unity gain", 32'h10001000, sample_out);
        access(1'b1, qmc_mixer_pkg::IDX_I_GAIN, 32'h00000200);
        access(1'b1, qmc_mixer_pkg::IDX_COARSE, 32'h00000200);
        cycles(10);
        check("gain held back", 32'h10001000, sample_out);
        access(1'b1, qmc_mixer_pkg::IDX_CORR_EN, 32'h00000001);
        access(1'b1, qmc_mixer_pkg::IDX_PHASE, 32'h00003000);
        rd(qmc_mixer_pkg::IDX_PHASE, 32'h00003000);
        cycles(10);
        check("group load", 32'h08000800, sample_out);
        access(1'b1, qmc_mixer_pkg::IDX_PHASE, 32'h00003800);
        cycles(10);
        check("phase correction", 32'h04000800, sample_out);
        rd(qmc_mixer_pkg::IDX_ACTIVE_STAT, 32'h00000800);
        access(1'b1, qmc_mixer_pkg::IDX_COARSE, 32'h00005200);
        cycles(10);
        check("cancelling shifts", 32'h04000800, sample_out);
        access(1'b1, qmc_mixer_pkg::IDX_COARSE, 32'h00002200);
        cycles(10);
        first = sample_out.a;
        cycles(1);
        check("half rate flip", 32'h0, {16'h0, first + sample_out.a});
        access(1'b1, qmc_mixer_pkg::IDX_STEP_LO, 32'h00000000);
        access(1'b1, qmc_mixer_pkg::IDX_STEP_HI, 32'h00000001);
        cycles(4);
        check("step held back", 32'h0, {16'h0, osc_table_addr});
        access(1'b1, qmc_mixer_pkg::IDX_MIX_EN, 32'h00000001);
        access(1'b1, qmc_mixer_pkg::IDX_OSC_OFS, 32'h00000100);
        cycles(4);
        first = osc_table_addr;
        cycles(1);
        check("table step", 32'h1, {16'h0, osc_table_addr - first});
        access(1'b1, qmc_mixer_pkg::IDX_CORR_EN, 32'h00000000);
        rd(qmc_mixer_pkg::IDX_CORR_EN, 32'h00000000);
        access(1'b1, qmc_mixer_pkg::IDX_PHASE, 32'h00003000);
        rd(qmc_mixer_pkg::IDX_ACTIVE_STAT, 32'h00000800);
        access(1'b1, qmc_mixer_pkg::IDX_GROUP_LOAD, 32'h00000001);
        rd(qmc_mixer_pkg::IDX_GROUP_LOAD, 32'h00000000);
        rd(qmc_mixer_pkg::IDX_ACTIVE_STAT, 32'h00000000);
        complete_run();
    end

    // A hung handshake is cut off well past the expected run of under two hundred cycles.
    initial begin
        #20000;
        errors++;
        complete_run();
    end
endmodule
